// [src/radio_ctrl_map.vh]
`ifndef RADIO_CTRL_MAP_VH
`define RADIO_CTRL_MAP_VH

// Control word width and field positions.
`define CW_WIDTH        32
`define CW_FIXED_HI     31
`define CW_FIXED_LO     16
`define CW_TCOMP_HI     26
`define CW_TCOMP_LO     23
`define CW_REFSEL_HI    13
`define CW_REFSEL_LO    12
`define CW_PWR_HI       11
`define CW_PWR_LO       10
`define CW_PLLHOLD      9
`define CW_RXSEL        8
`define CW_FREQ_HI      7
`define CW_FREQ_LO      0

// Fixed pattern carried in the upper half of a well-formed word.
`define CW_FIXED_PATTERN 16'h0546
`define CW_RESET_VALUE   32'h00000000

// Reference divider ratios for each select code.
`define REFDIV_00 5'h0C
`define REFDIV_01 5'h10
`define REFDIV_10 5'h0D
`define REFDIV_11 5'h1A

// Synthesizer base frequency in MHz.
`define VCO_BASE_MHZ 12'h900

// Access-code refinement span in bits.
`define DC_REFINE_BITS 10

`endif

// [src/dc_phase_seq.v]
`timescale 1ns/1ps
`include "radio_ctrl_map.vh"

module dc_phase_seq (
    input  wire       core_clk,     // System clock.
    input  wire       rst,          // Synchronous reset, active high.
    input  wire       rxMode,       // Receive slot selected.
    input  wire       strobeSync,   // Synchronised DC strobe level.
    input  wire       slotReset,    // Power-down state set by the serial enable pulse.
    output reg  [1:0] dcPhase_r,    // 0 idle, 1 coarse, 2 integrate, 3 hold.
    output reg        seedPulse_r   // One cycle when the integrator is seeded.
);

    localparam PH_IDLE   = 2'h0;
    localparam PH_COARSE = 2'h1;
    localparam PH_INTEG  = 2'h2;
    localparam PH_HOLD   = 2'h3;

    reg       strobeDly_r;
    reg [1:0] dcPhase_nxt;

    // Idle steps straight to coarse; later transitions follow strobe edges; a transmit slot ignores the strobe.
    always @* begin
        dcPhase_nxt = dcPhase_r;
        if (slotReset || !rxMode) begin
            dcPhase_nxt = PH_IDLE;
        end else begin
            case (dcPhase_r)
                PH_IDLE:   dcPhase_nxt = PH_COARSE;
                PH_COARSE: if (strobeSync && !strobeDly_r) dcPhase_nxt = PH_INTEG;
                PH_INTEG:  if (!strobeSync) dcPhase_nxt = PH_HOLD;
                default:   dcPhase_nxt = dcPhase_r;
            endcase
        end
    end

    // Register the phase and flag the seeding moment.
    always @(posedge core_clk) begin
        if (rst) begin
            dcPhase_r   <= PH_IDLE;
            strobeDly_r <= 1'b0;
            seedPulse_r <= 1'b0;
        end else begin
            dcPhase_r   <= dcPhase_nxt;
            strobeDly_r <= strobeSync;
            seedPulse_r <= (dcPhase_r == PH_COARSE) && (dcPhase_nxt == PH_INTEG);
        end
    end

endmodule // dc_phase_seq

// [src/radio_control_word_and_dc_sequencer.v]
`timescale 1ns/1ps
`include "radio_ctrl_map.vh"

// Behaviour
// - Bits 26..23 act as temperature compensation.
// - Bits 13:12 pick reference divider ratio.
// - Bits 11:10 pick transmit power level.
// - Bit 8 set selects receive mode.
// - Bit 9 set keeps loop closed.
// - Bit 9 clear allows loop opening.
// - VCO frequency is 2304 plus n.
// - Slicer threshold derived via strobed extractor.
// - Strobe low gives coarse min/max estimate.
// - Strobe rise seeds integrator, refines threshold.
// - Strobe fall holds threshold, tracks drift.
// - MSB first, keep only last 32 bits.
// - Ignore bus while enable high; load on rise.
// - Enable falling edge controls loop opening.
// - Short enable pulse resets and powers down.
module radio_control_word_and_dc_sequencer #(
    parameter CW_W = `CW_WIDTH              // Control word width.
) (
    input  wire            core_clk,        // System clock, 100 MHz.
    input  wire            rst,             // Synchronous reset, active high.
    input  wire            serData,         // Serial bus data pin.
    input  wire            serClk,          // Serial bus clock pin.
    input  wire            serEn,           // Serial bus enable pin, low frames a burst.
    input  wire            dc_strobe,       // DC extractor strobe pin.
    output reg  [CW_W-1:0] controlWord_r,   // Loaded control word.
    output reg  [3:0]      tempComp_r,      // Temperature compensation setting.
    output reg  [4:0]      refDivRatio_r,   // Reference divider ratio.
    output reg  [1:0]      powerSel_r,      // Transmit power code, 01 nominal.
    output reg             rxMode_r,        // High in receive slot.
    output reg             pllHold_r,       // Loop held closed for the slot.
    output reg             pllClosed_r,     // Synthesizer loop currently closed.
    output reg  [11:0]     vcoFreqMhz_r,    // Synthesizer frequency in MHz.
    output reg             patternOk_r,     // Upper fixed pattern matched at load.
    output reg             poweredDown_r,   // Device in power-down.
    output wire [1:0]      dcPhase,         // DC extractor phase.
    output wire            dcSeed           // Integrator seed pulse.
);

    // Divider ratio lookup for the reference select code.
    function [4:0] refDiv;
        input [1:0] code;
        begin
            case (code)
                2'h0:    refDiv = `REFDIV_00;
                2'h1:    refDiv = `REFDIV_01;
                2'h2:    refDiv = `REFDIV_10;
                default: refDiv = `REFDIV_11;
            endcase
        end
    endfunction

    // Two-stage synchronisers for every pin.
    reg [1:0] dataSync_r;
    reg [1:0] clkSync_r;
    reg [1:0] enSync_r;
    reg [1:0] strobeSync_r;
    reg       clkPrev_r;
    reg       enPrev_r;
    reg [CW_W-1:0] shift_r;
    reg       loadPend_r;

    wire sData   = dataSync_r[1];
    wire sClk    = clkSync_r[1];
    wire sEn     = enSync_r[1];
    wire clkRise = sClk && !clkPrev_r;
    wire enRise  = sEn && !enPrev_r;
    wire enFall  = !sEn && enPrev_r;

    // The first flop of each pair feeds only the second.
    always @(posedge core_clk) begin
        if (rst) begin
            dataSync_r   <= 2'h0;
            clkSync_r    <= 2'h0;
            enSync_r     <= 2'h3;
            strobeSync_r <= 2'h0;
            clkPrev_r    <= 1'b0;
            enPrev_r     <= 1'b1;
        end else begin
            dataSync_r   <= {dataSync_r[0], serData};
            clkSync_r    <= {clkSync_r[0], serClk};
            enSync_r     <= {enSync_r[0], serEn};
            strobeSync_r <= {strobeSync_r[0], dc_strobe};
            clkPrev_r    <= sClk;
            enPrev_r     <= sEn;
        end
    end

    // Data passes the same two-stage delay as the clock and is sampled in the cycle the synced clock rise is seen.
    // Shifting continues with no count; older bits just fall off the top.
    always @(posedge core_clk) begin
        if (rst) begin
            shift_r <= `CW_RESET_VALUE;
        end else if (clkRise && !sEn) begin
            shift_r <= {shift_r[CW_W-2:0], sData};
        end
    end

    // Load on enable rise; a burst with no clocks is a power-down pulse.
    reg sawClk_r;
    always @(posedge core_clk) begin
        if (rst) begin
            sawClk_r   <= 1'b0;
            loadPend_r <= 1'b0;
        end else begin
            loadPend_r <= enRise;
            // A clock edge landing in the enable-fall cycle is shifted, so it must count as seen.
            if (clkRise && !sEn) begin
                sawClk_r <= 1'b1;
            end else if (enFall) begin
                sawClk_r <= 1'b0;
            end
        end
    end

    // Control word and its decoded fields.
    always @(posedge core_clk) begin
        if (rst) begin
            controlWord_r <= `CW_RESET_VALUE;
            tempComp_r    <= 4'h0;
            refDivRatio_r <= `REFDIV_00;
            powerSel_r    <= 2'h0;
            rxMode_r      <= 1'b0;
            pllHold_r     <= 1'b0;
            vcoFreqMhz_r  <= `VCO_BASE_MHZ;
            patternOk_r   <= 1'b0;
        end else if (loadPend_r && sawClk_r) begin
            controlWord_r <= shift_r;
            tempComp_r    <= shift_r[`CW_TCOMP_HI:`CW_TCOMP_LO];
            refDivRatio_r <= refDiv(shift_r[`CW_REFSEL_HI:`CW_REFSEL_LO]);
            powerSel_r    <= shift_r[`CW_PWR_HI:`CW_PWR_LO];
            rxMode_r      <= shift_r[`CW_RXSEL];
            pllHold_r     <= shift_r[`CW_PLLHOLD];
            vcoFreqMhz_r  <= `VCO_BASE_MHZ + {4'h0, shift_r[`CW_FREQ_HI:`CW_FREQ_LO]};
            // Compensation bits are excluded from the pattern check.
            patternOk_r   <= (shift_r[31:27] == 5'h00) && (shift_r[22:16] == 7'h46)
                             && (shift_r[15:14] == 2'h0);
        end
    end

    // Power state: a clockless enable pulse powers down, a real load wakes up.
    always @(posedge core_clk) begin
        if (rst) begin
            poweredDown_r <= 1'b1;
        end else if (loadPend_r) begin
            poweredDown_r <= !sawClk_r;
        end
    end

    // Loop control: closed after programming, opened on enable fall unless held.
    always @(posedge core_clk) begin
        if (rst) begin
            pllClosed_r <= 1'b0;
        end else if (poweredDown_r && !loadPend_r) begin
            pllClosed_r <= 1'b0;
        end else if (loadPend_r) begin
            pllClosed_r <= sawClk_r;
        end else if (enFall && !pllHold_r) begin
            pllClosed_r <= 1'b0;
        end
    end

    // Extractor phase sequencer driven by the synchronised strobe.
    dc_phase_seq u_dcSeq (
        .core_clk    (core_clk),
        .rst         (rst),
        .rxMode      (rxMode_r),
        .strobeSync  (strobeSync_r[1]),
        .slotReset   (poweredDown_r),
        .dcPhase_r   (dcPhase),
        .seedPulse_r (dcSeed)
    );

endmodule // radio_control_word_and_dc_sequencer

// [bench/radio_ctrl_asserts.sv]
`timescale 1ns/1ps
module radio_ctrl_asserts #(
    parameter CW_W = 32                    // Control word width.
) (
    input wire            core_clk,        // Clock.
    input wire            rst,             // Reset.
    input wire [CW_W-1:0] controlWord_r,   // Word.
    input wire [4:0]      refDivRatio_r,   // Ratio.
    input wire [1:0]      powerSel_r,      // Power.
    input wire            rxMode_r,        // Receive.
    input wire            pllHold_r,       // Hold.
    input wire            pllClosed_r,     // Loop.
    input wire [11:0]     vcoFreqMhz_r,    // Frequency.
    input wire            poweredDown_r,   // Down.
    input wire [1:0]      dcPhase,         // Phase.
    input wire            dcSeed           // Seed.
);
    // All checks live in the core clock domain, so one clocking and one disable serve them.
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_tx2; !rxMode_r [*2]; endsequence
    sequence s_seedEnd; dcPhase == 2'h2 ##1 !dcSeed; endsequence
    property p_ref; refDivRatio_r == (controlWord_r[13] ? (controlWord_r[12] ? 5'h1A : 5'h0D)
        : (controlWord_r[12] ? 5'h10 : 5'h0C)); endproperty
    a_ref: assert property (p_ref) else $error("ratio wrong");
    property p_pwr; powerSel_r == controlWord_r[11:10]; endproperty
    a_pwr: assert property (p_pwr) else $error("power wrong");
    property p_rx; rxMode_r == controlWord_r[8]; endproperty
    a_rx: assert property (p_rx) else $error("mode wrong");
    property p_vco; vcoFreqMhz_r == 12'h900 + controlWord_r[7:0]; endproperty
    a_vco: assert property (p_vco) else $error("frequency wrong");
    property p_hold; !poweredDown_r && pllHold_r |-> pllClosed_r; endproperty
    a_hold: assert property (p_hold) else $error("held loop opened");
    property p_open; $fell(pllClosed_r) |-> !pllHold_r || poweredDown_r; endproperty
    a_open: assert property (p_open) else $error("loop opened while held");
    property p_seed; dcSeed |-> s_seedEnd; endproperty
    a_seed: assert property (p_seed) else $error("seed pulse wrong");
    property p_tx; s_tx2 |-> dcPhase == 2'h0; endproperty
    a_tx: assert property (p_tx) else $error("phase moved in transmit");
endmodule // radio_ctrl_asserts

bind radio_control_word_and_dc_sequencer radio_ctrl_asserts #(.CW_W(CW_W)) radio_ctrl_asserts_i (
    .core_clk(core_clk), .rst(rst), .controlWord_r(controlWord_r), .refDivRatio_r(refDivRatio_r),
    .powerSel_r(powerSel_r), .rxMode_r(rxMode_r), .pllHold_r(pllHold_r), .pllClosed_r(pllClosed_r),
    .vcoFreqMhz_r(vcoFreqMhz_r), .poweredDown_r(poweredDown_r), .dcPhase(dcPhase), .dcSeed(dcSeed));

// [bench/radio_bb_host.sv]
`timescale 1ns/1ps
module radio_bb_host (
    output logic serData,    // Data, pull-down level when idle.
    output logic serClk,     // Clock, still outside bursts.
    output logic serEn,      // Enable, low frames a burst.
    output logic dc_strobe   // Strobe, low through coarse phase.
);
    // Idle bus: enable high, the other lines at their pull-down level.
    initial begin
        serData = 1'b0;
        serClk = 1'b0;
        serEn = 1'b1;
        dc_strobe = 1'b0;
    end
    // Data moves at the falling edge, so it is stable 40 ns either side of each rise.
    task automatic send(input logic [39:0] w, input int n, input logic act);
        serEn <= !act;
        for (int i = n - 1; i >= 0; i--) begin
            serData <= w[i];
            #40 serClk <= 1'b1;
            #40 serClk <= 1'b0;
        end
        #40 serEn <= 1'b1;
        serData <= 1'b0;
    endtask
    // Enable burst with no clocks is the end-of-slot power-down pulse.
    task automatic pulse();
        serEn <= 1'b0;
        #200 serEn <= 1'b1;
    endtask
    // Raised 20 us before the expected trailer end and dropped at the end itself.
    task automatic strobe();
        dc_strobe <= 1'b1;
        #20000 dc_strobe <= 1'b0;
    endtask
endmodule // radio_bb_host

// [bench/radio_control_word_and_dc_sequencer_test.sv]
`timescale 1ns/1ps
module radio_control_word_and_dc_sequencer_test;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    wire         serData, serClk, serEn, dc_strobe, rxMode_r, pllHold_r, pllClosed_r, patternOk_r;
    wire         poweredDown_r, dcSeed;
    wire  [31:0] controlWord_r;
    wire  [3:0]  tempComp_r;
    wire  [4:0]  refDivRatio_r;
    wire  [1:0]  powerSel_r, dcPhase;
    wire  [11:0] vcoFreqMhz_r;
    int          bad_count = 0;
    int          n_compared = 0;
    logic [4:0]  ratio [4] = '{5'h0C, 5'h10, 5'h0D, 5'h1A};
    logic [31:0] w;
    logic [7:0]  seedCount = 8'h00;
    radio_control_word_and_dc_sequencer radio_control_word_and_dc_sequencer_i (
        .core_clk(core_clk), .rst(rst), .serData(serData), .serClk(serClk), .serEn(serEn),
        .dc_strobe(dc_strobe), .controlWord_r(controlWord_r), .tempComp_r(tempComp_r),
        .refDivRatio_r(refDivRatio_r), .powerSel_r(powerSel_r), .rxMode_r(rxMode_r), .pllHold_r(pllHold_r),
        .pllClosed_r(pllClosed_r), .vcoFreqMhz_r(vcoFreqMhz_r), .patternOk_r(patternOk_r),
        .poweredDown_r(poweredDown_r), .dcPhase(dcPhase), .dcSeed(dcSeed));
    radio_bb_host radio_bb_host_i (.serData(serData), .serClk(serClk), .serEn(serEn), .dc_strobe(dc_strobe));
    // 100 MHz core clock.
    always #5 core_clk = ~core_clk;
    // The seed pulse stands for one cycle only, so it is counted here rather than polled.
    always @(posedge core_clk) begin
        if (dcSeed === 1'b1) begin
            seedCount <= seedCount + 8'h01;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Eight junk leading bits go first; the fields settle within about five cycles.
    task automatic load(input logic [31:0] v);
        radio_bb_host_i.send({8'hFF, v}, 40, 1'b1);
        repeat (10) @(posedge core_clk);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("ratio", 5'h0C, refDivRatio_r);
        chk("vco", 12'h900, vcoFreqMhz_r);
        chk("down", 1'b1, poweredDown_r);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            w = {5'h00, i[1:0], ~i[1:0], 7'h46, 2'h0, i[1:0], i[1:0], 2'h0, 8'h62 + i[7:0]};
            load(w);
            chk("word", w, controlWord_r);
            chk("tcomp", w[26:23], tempComp_r);
            chk("ratio", ratio[i], refDivRatio_r);
            chk("power", i, powerSel_r);
            chk("vco", 12'h962 + i, vcoFreqMhz_r);
            chk("down", 1'b0, poweredDown_r);
            chk("pattern", 1'b1, patternOk_r);
        end
        radio_bb_host_i.send(40'h0, 40, 1'b0);
        repeat (10) @(posedge core_clk);
        chk("ignored", w, controlWord_r);
        radio_bb_host_i.send(40'h63, 8, 1'b1);
        repeat (10) @(posedge core_clk);
        chk("short", {w[23:0], 8'h63}, controlWord_r);
        chk("pattern", 1'b0, patternOk_r);
        $display("field test done");
        load(32'h05460563);
        chk("rx", 1'b1, rxMode_r);
        chk("phase", 2'h1, dcPhase);
        fork radio_bb_host_i.strobe(); begin #1000 chk("phase", 2'h2, dcPhase); end join
        repeat (5) @(posedge core_clk);
        chk("phase", 2'h3, dcPhase);
        chk("seed", 8'h01, seedCount);
        fork radio_bb_host_i.pulse(); begin #150 chk("closed", 1'b0, pllClosed_r); end join
        repeat (10) @(posedge core_clk);
        chk("down", 1'b1, poweredDown_r);
        chk("phase", 2'h0, dcPhase);
        load(32'h05460763);
        chk("hold", 1'b1, pllHold_r);
        fork load(32'h05460763); begin #2000 chk("closed", 1'b1, pllClosed_r); end join
        load(32'h05460462);
        fork radio_bb_host_i.strobe(); begin #1000 chk("phase", 2'h0, dcPhase); end join
        chk("seed", 8'h01, seedCount);
        $display("receive test done");
        results();
    end
    // Cuts a hung run short; the tests need just under a tenth of this span.
    initial begin
        #800000;
        bad_count++;
        results();
    end
endmodule // radio_control_word_and_dc_sequencer_test
